// file: core/tpm_pkg.sv
// How it works
// - An 8-bit counter adds one for each severely errored frame up to 255 and holds that count until the next read.
// - In superframe mode a severely errored frame is declared after six superframes in a row with framing bit errors.
// - In extended superframe mode it is declared after twenty-four extended superframes in a row with pattern errors.
// - CRC-6 sync bit errors are counted in 16 bits, shown as an upper-byte register and a lower-byte register.
// - An 8-bit counter adds one for each receive slip up to 255, that is each frame duplicated or dropped.
// - Every counter clears when read, comes out of reset at zero and counts again from zero after a read.
package tpm_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [11:0] IDX_SEF      = 12'h904;
   localparam logic [11:0] IDX_CRC_HI   = 12'h905;
   localparam logic [11:0] IDX_CRC_LO   = 12'h906;
   localparam logic [11:0] IDX_SLIP     = 12'h90a;
   localparam logic [11:0] IDX_INT_STAT = 12'h910;
   localparam logic [11:0] IDX_INT_MASK = 12'h911;
   localparam int          ADDR_W       = 16;
   // Run lengths that declare a severely errored frame, and the times they span.
   localparam real         SF_SEF_TIME_MS  = 0.75;
   localparam real         ESF_SEF_TIME_MS = 3.0;
   localparam logic [4:0]  SF_RUN       = 5'h06;
   localparam logic [4:0]  ESF_RUN      = 5'h18;
   // Interrupt status and mask bit positions.
   localparam int          INT_SEF      = 0;
   localparam int          INT_CRC      = 1;
   localparam int          INT_SLIP     = 2;
   localparam int          INT_W        = 3;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   localparam logic [7:0]  CNT8_RST     = 8'h00;
   localparam logic [15:0] CNT16_RST    = 16'h0000;
   localparam logic [7:0]  CNT8_MAX     = 8'hff;
   localparam logic [15:0] CNT16_MAX    = 16'hffff;

   // Event pulses from the receive framer and slip buffer.
   typedef struct packed {
      logic sf_end;
      logic sf_fbit_err;
      logic crc6_err;
      logic slip;
   } tpm_evt_t;

   function automatic logic [ADDR_W-1:0] tpm_addr(input logic [11:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction : tpm_addr
endpackage : tpm_pkg

// file: core/tpm_top.sv
`timescale 1ns/1ps
module tpm_top (
   input  wire logic                      i_mclk,
   input  wire logic                      i_rstn,
   input  wire tpm_pkg::tpm_evt_t         i_evt,
   input  wire logic                      i_esf_mode,
   input  wire logic [tpm_pkg::ADDR_W-1:0] i_awaddr,
   input  wire logic                      i_awvalid,
   output logic                           o_awready,
   input  wire logic [31:0]               i_wdata,
   input  wire logic [3:0]                i_wstrb,
   input  wire logic                      i_wvalid,
   output logic                           o_wready,
   output logic [1:0]                     o_bresp,
   output logic                           o_bvalid,
   input  wire logic                      i_bready,
   input  wire logic [tpm_pkg::ADDR_W-1:0] i_araddr,
   input  wire logic                      i_arvalid,
   output logic                           o_arready,
   output logic [31:0]                    o_rdata,
   output logic [1:0]                     o_rresp,
   output logic                           o_rvalid,
   input  wire logic                      i_rready,
   output logic                           o_irq
);
   // Saturating increments; a counter that tops out sticks rather than wrapping to a misleading low value.
   function automatic logic [7:0] bump8(input logic [7:0] v, input logic en, input logic clr);
      logic [7:0] b;
      b = clr ? tpm_pkg::CNT8_RST : v;
      return (en && b != tpm_pkg::CNT8_MAX) ? b + 8'h01 : b;
   endfunction : bump8

   function automatic logic [15:0] bump16(input logic [15:0] v, input logic en, input logic clr);
      logic [15:0] b;
      b = clr ? tpm_pkg::CNT16_RST : v;
      return (en && b != tpm_pkg::CNT16_MAX) ? b + 16'h0001 : b;
   endfunction : bump16

   logic                      awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
   logic                      arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0]                bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0]               rdata_q, rdata_d, wdata_q, wdata_d;
   logic [3:0]                wstrb_q, wstrb_d;
   logic [tpm_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [4:0]                run_q, run_d;
   logic                      sef_pulse;
   logic [7:0]                sef_cnt_q, sef_cnt_d, slip_cnt_q, slip_cnt_d, hold_q, hold_d;
   logic [15:0]               crc_cnt_q, crc_cnt_d;
   logic [tpm_pkg::INT_W-1:0] stat_q, stat_d, mask_q, mask_d, set_bits;
   logic                      irq_q, irq_d;
   logic                      rd_go, wr_go, clr_sef, clr_crc, clr_slip;

   assign rd_go = i_arvalid && arready_q;
   assign wr_go = !awready_q && !wready_q && !bvalid_q;

   // Severely errored frame detector: count superframes in a row whose framing bits were all in error.
   always_comb begin
      logic [4:0] target;
      target    = i_esf_mode ? tpm_pkg::ESF_RUN : tpm_pkg::SF_RUN;
      run_d     = run_q;
      sef_pulse = 1'b0;
      if (i_evt.sf_end) begin
         if (!i_evt.sf_fbit_err) begin
            run_d = 5'h00;
         end else if (run_q + 5'h01 >= target) begin
            sef_pulse = 1'b1;
            run_d     = 5'h00; // A new window starts after each declaration.
         end else begin
            run_d = run_q + 5'h01;
         end
      end
   end

   // Read decode; reads clear the counters they return.
   always_comb begin
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      arready_d = arready_q;
      rvalid_d  = rvalid_q;
      hold_d    = hold_q;
      clr_sef   = 1'b0;
      clr_crc   = 1'b0;
      clr_slip  = 1'b0;
      if (rvalid_q && i_rready) begin
         rvalid_d  = 1'b0;
         arready_d = 1'b1;
      end
      if (rd_go) begin
         arready_d = 1'b0;
         rvalid_d  = 1'b1;
         rresp_d   = tpm_pkg::RESP_OKAY;
         rdata_d   = 32'h0000_0000;
         unique case (i_araddr)
            tpm_pkg::tpm_addr(tpm_pkg::IDX_SEF): begin
               rdata_d[7:0] = sef_cnt_q;
               clr_sef      = 1'b1;
            end
            tpm_pkg::tpm_addr(tpm_pkg::IDX_CRC_HI): begin
               rdata_d[7:0] = crc_cnt_q[15:8];
               hold_d       = crc_cnt_q[7:0];
               clr_crc      = 1'b1;
            end
            tpm_pkg::tpm_addr(tpm_pkg::IDX_CRC_LO): begin
               rdata_d[7:0] = hold_q;
            end
            tpm_pkg::tpm_addr(tpm_pkg::IDX_SLIP): begin
               rdata_d[7:0] = slip_cnt_q;
               clr_slip     = 1'b1;
            end
            tpm_pkg::tpm_addr(tpm_pkg::IDX_INT_STAT): rdata_d[tpm_pkg::INT_W-1:0] = stat_q;
            tpm_pkg::tpm_addr(tpm_pkg::IDX_INT_MASK): rdata_d[tpm_pkg::INT_W-1:0] = mask_q;
            default: rresp_d = tpm_pkg::RESP_SLVERR;
         endcase
      end
   end

   // Counters; an event in the clearing cycle counts as the first of the new total.
   always_comb begin
      sef_cnt_d  = bump8(sef_cnt_q, sef_pulse, clr_sef);
      crc_cnt_d  = bump16(crc_cnt_q, i_evt.crc6_err, clr_crc);
      slip_cnt_d = bump8(slip_cnt_q, i_evt.slip, clr_slip);
   end

   // Write channel: address and data are taken independently, then the write is done and answered.
   always_comb begin
      logic [tpm_pkg::INT_W-1:0] w1c;
      w1c       = '0;
      awready_d = awready_q;
      wready_d  = wready_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      mask_d    = mask_q;
      if (i_awvalid && awready_q) begin
         awready_d = 1'b0;
         awaddr_d  = i_awaddr;
      end
      if (i_wvalid && wready_q) begin
         wready_d = 1'b0;
         wdata_d  = i_wdata;
         wstrb_d  = i_wstrb;
      end
      if (wr_go) begin
         bvalid_d = 1'b1;
         bresp_d  = tpm_pkg::RESP_OKAY;
         unique case (awaddr_q)
            tpm_pkg::tpm_addr(tpm_pkg::IDX_INT_STAT): begin
               if (wstrb_q[0]) begin
                  w1c = wdata_q[tpm_pkg::INT_W-1:0];
               end
            end
            tpm_pkg::tpm_addr(tpm_pkg::IDX_INT_MASK): begin
               if (wstrb_q[0]) begin
                  mask_d = wdata_q[tpm_pkg::INT_W-1:0];
               end
            end
            // Counters are read-only; writes to them are accepted and have no effect.
            tpm_pkg::tpm_addr(tpm_pkg::IDX_SEF), tpm_pkg::tpm_addr(tpm_pkg::IDX_CRC_HI),
            tpm_pkg::tpm_addr(tpm_pkg::IDX_CRC_LO), tpm_pkg::tpm_addr(tpm_pkg::IDX_SLIP): ;
            default: bresp_d = tpm_pkg::RESP_SLVERR;
         endcase
      end
      if (bvalid_q && i_bready) begin
         bvalid_d  = 1'b0;
         awready_d = 1'b1;
         wready_d  = 1'b1;
      end
      set_bits                   = '0;
      set_bits[tpm_pkg::INT_SEF]  = sef_pulse;
      set_bits[tpm_pkg::INT_CRC]  = i_evt.crc6_err;
      set_bits[tpm_pkg::INT_SLIP] = i_evt.slip;
      // Set wins over a clear arriving in the same cycle.
      stat_d = (stat_q & ~w1c) | set_bits;
      irq_d  = |(stat_d & mask_d);
   end

   // State registers.
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         awready_q  <= 1'b1;
         wready_q   <= 1'b1;
         bvalid_q   <= 1'b0;
         bresp_q    <= tpm_pkg::RESP_OKAY;
         awaddr_q   <= '0;
         wdata_q    <= 32'h0000_0000;
         wstrb_q    <= 4'h0;
         arready_q  <= 1'b1;
         rvalid_q   <= 1'b0;
         rresp_q    <= tpm_pkg::RESP_OKAY;
         rdata_q    <= 32'h0000_0000;
         run_q      <= 5'h00;
         sef_cnt_q  <= tpm_pkg::CNT8_RST;
         crc_cnt_q  <= tpm_pkg::CNT16_RST;
         slip_cnt_q <= tpm_pkg::CNT8_RST;
         hold_q     <= tpm_pkg::CNT8_RST;
         stat_q     <= '0;
         mask_q     <= '0;
         irq_q      <= 1'b0;
      end else begin
         awready_q  <= awready_d;
         wready_q   <= wready_d;
         bvalid_q   <= bvalid_d;
         bresp_q    <= bresp_d;
         awaddr_q   <= awaddr_d;
         wdata_q    <= wdata_d;
         wstrb_q    <= wstrb_d;
         arready_q  <= arready_d;
         rvalid_q   <= rvalid_d;
         rresp_q    <= rresp_d;
         rdata_q    <= rdata_d;
         run_q      <= run_d;
         sef_cnt_q  <= sef_cnt_d;
         crc_cnt_q  <= crc_cnt_d;
         slip_cnt_q <= slip_cnt_d;
         hold_q     <= hold_d;
         stat_q     <= stat_d;
         mask_q     <= mask_d;
         irq_q      <= irq_d;
      end
   end

   assign o_awready = awready_q;
   assign o_wready  = wready_q;
   assign o_bvalid  = bvalid_q;
   assign o_bresp   = bresp_q;
   assign o_arready = arready_q;
   assign o_rvalid  = rvalid_q;
   assign o_rresp   = rresp_q;
   assign o_rdata   = rdata_q;
   assign o_irq     = irq_q;

   // Checks on the counters and the bus answers.
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);

   sequence s_hi_rd;
      rd_go && i_araddr == tpm_pkg::tpm_addr(tpm_pkg::IDX_CRC_HI);
   endsequence
   sequence s_lo_rd;
      rd_go && i_araddr == tpm_pkg::tpm_addr(tpm_pkg::IDX_CRC_LO);
   endsequence

   AST_SEF_COUNT: assert property (sef_pulse && !clr_sef && sef_cnt_q != tpm_pkg::CNT8_MAX
      |=> sef_cnt_q == $past(sef_cnt_q) + 8'h01) else $error("Severe frame count did not advance.");
   // A switch from extended to plain superframe mode may leave a longer run behind, so only a floor is checked here.
   AST_SF_RUN: assert property (sef_pulse && !i_esf_mode
      |-> run_q >= tpm_pkg::SF_RUN - 5'h01 && i_evt.sf_fbit_err) else $error("Superframe declaration off count.");
   AST_ESF_RUN: assert property (sef_pulse && i_esf_mode
      |-> run_q == tpm_pkg::ESF_RUN - 5'h01) else $error("Extended superframe declaration off count.");
   AST_CRC_COUNT: assert property (i_evt.crc6_err && !clr_crc && crc_cnt_q != tpm_pkg::CNT16_MAX
      |=> crc_cnt_q == $past(crc_cnt_q) + 16'h0001) else $error("CRC-6 count did not advance.");
   AST_HI_LO_PAIR: assert property (s_hi_rd ##[2:20] s_lo_rd
      |=> rdata_q[7:0] == hold_q) else $error("Lower byte not the captured value.");
   AST_HI_CAPTURE: assert property (s_hi_rd |=> hold_q == $past(crc_cnt_q[7:0])
      && rdata_q[7:0] == $past(crc_cnt_q[15:8])) else $error("Upper read did not capture.");
   AST_SLIP_COUNT: assert property (i_evt.slip && !clr_slip && slip_cnt_q != tpm_pkg::CNT8_MAX
      |=> slip_cnt_q == $past(slip_cnt_q) + 8'h01) else $error("Slip count did not advance.");
   AST_READ_CLEAR: assert property (clr_slip && !i_evt.slip |=> slip_cnt_q == tpm_pkg::CNT8_RST
      ##0 rvalid_q) else $error("Slip counter not cleared by read.");
   AST_CRC_CLEAR: assert property (clr_crc && !i_evt.crc6_err
      |=> crc_cnt_q == tpm_pkg::CNT16_RST) else $error("CRC-6 counter not cleared by read.");
   AST_IRQ_LEVEL: assert property (o_irq == |(stat_q & mask_q)) else $error("Interrupt level mismatch.");
   AST_READ_ANSWER: assert property (rd_go |=> o_rvalid && !o_arready) else $error("Read not answered.");

   // Saturation and clear-versus-event corners, which short tests seldom reach, then the run, status and handshake checks.
   // A full severe frame counter must stick rather than wrap to a misleading low value.
   AST_SEF_SAT: assert property (sef_pulse && !clr_sef && sef_cnt_q == tpm_pkg::CNT8_MAX
      |=> sef_cnt_q == tpm_pkg::CNT8_MAX) else $error("Severe frame count wrapped.");
   // A read of the severe frame counter with no new declaration leaves it at zero.
   AST_SEF_CLEAR: assert property (clr_sef && !sef_pulse
      |=> sef_cnt_q == tpm_pkg::CNT8_RST) else $error("Severe frame counter not cleared by read.");
   // A declaration in the clearing cycle is the first of the new total.
   AST_SEF_CLR_EVT: assert property (clr_sef && sef_pulse
      |=> sef_cnt_q == tpm_pkg::CNT8_RST + 8'h01) else $error("Severe frame lost in clearing cycle.");
   // A full sync bit error counter must stick as well.
   AST_CRC_SAT: assert property (i_evt.crc6_err && !clr_crc && crc_cnt_q == tpm_pkg::CNT16_MAX
      |=> crc_cnt_q == tpm_pkg::CNT16_MAX) else $error("CRC-6 count wrapped.");
   // A full slip counter must stick as well.
   AST_SLIP_SAT: assert property (i_evt.slip && !clr_slip && slip_cnt_q == tpm_pkg::CNT8_MAX
      |=> slip_cnt_q == tpm_pkg::CNT8_MAX) else $error("Slip count wrapped.");
   // A slip in the clearing cycle is the first of the new total.
   AST_SLIP_CLR_EVT: assert property (clr_slip && i_evt.slip
      |=> slip_cnt_q == tpm_pkg::CNT8_RST + 8'h01) else $error("Slip lost in clearing cycle.");
   // A lower-byte read must not disturb the captured byte, so a repeated read returns the same value.
   AST_LO_KEEPS_HOLD: assert property (s_lo_rd
      |=> hold_q == $past(hold_q)) else $error("Lower-byte read changed the captured value.");
   // One clean superframe breaks the run of errored ones.
   AST_RUN_BREAK: assert property (i_evt.sf_end && !i_evt.sf_fbit_err
      |=> run_q == 5'h00) else $error("Run not broken by a clean superframe.");
   // Each errored superframe short of the threshold lengthens the run by one.
   AST_RUN_STEP: assert property (i_evt.sf_end && i_evt.sf_fbit_err && !sef_pulse
      |=> run_q == $past(run_q) + 5'h01) else $error("Run did not advance.");
   // An event sets its status bit even when software clears that bit in the same cycle.
   AST_STAT_SET_WINS: assert property (|set_bits
      |=> (stat_q & $past(set_bits)) == $past(set_bits)) else $error("Status event lost.");
   // Once both halves of a write are in, the answer follows and nothing new is taken meanwhile.
   AST_WRITE_ANSWER: assert property (wr_go
      |=> o_bvalid && !o_awready && !o_wready) else $error("Write not answered.");
   // After the read answer is taken the slave is ready for the next address at once.
   AST_READ_RELEASE: assert property (o_rvalid && i_rready
      |=> !o_rvalid && o_arready) else $error("Read channel not released.");
endmodule : tpm_top

// file: sim/tb_tpm_top.sv
`timescale 1ns/1ps
module tb_tpm_top;
   localparam tpm_pkg::tpm_evt_t EV_ERR  = 4'hc;
   localparam tpm_pkg::tpm_evt_t EV_GOOD = 4'h8;
   localparam tpm_pkg::tpm_evt_t EV_CRC  = 4'h2;
   localparam tpm_pkg::tpm_evt_t EV_SLIP = 4'h1;
   localparam logic [1:0]        OK      = tpm_pkg::RESP_OKAY;
   localparam logic [1:0]        BAD     = tpm_pkg::RESP_SLVERR;
   logic                         i_mclk, i_rstn, i_esf_mode, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   tpm_pkg::tpm_evt_t            i_evt;
   logic [tpm_pkg::ADDR_W-1:0]   i_awaddr, i_araddr;
   logic [31:0]                  i_wdata, o_rdata;
   logic [3:0]                   i_wstrb;
   logic [1:0]                   o_bresp, o_rresp;
   logic                         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
   int                           error_cnt, check_count;

   tpm_top DUT (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_evt(i_evt), .i_esf_mode(i_esf_mode),
      .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
      .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
      .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
      .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
      .i_rready(i_rready), .o_irq(o_irq));

   // Free-running 40 MHz clock.
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end

   // Byte address of a register index, worked out here rather than borrowed from the design.
   function automatic logic [15:0] adr(input logic [11:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction : adr

   task automatic end_sim();
      if (error_cnt == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim

   task automatic chk_d(input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk_d

   task automatic chk_r(input logic [1:0] e, input logic [1:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk_r

   // Read: the request is held until taken; the answer is sampled at the rvalid edge (rready stays high).
   task automatic rd_chk(input logic [11:0] idx, input logic [31:0] e, input logic [1:0] er);
      logic done;
      done = 1'b0;
      i_araddr  <= adr(idx);
      i_arvalid <= 1'b1;
      while (!done) begin
         @(posedge i_mclk);
         if (i_arvalid && o_arready)
            i_arvalid <= 1'b0;
         if (o_rvalid) begin
            chk_d(e, o_rdata);
            chk_r(er, o_rresp);
            done = 1'b1;
         end
      end
   endtask : rd_chk

   // Write: address and data offered together, each released on its own handshake.
   task automatic wr_chk(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er);
      logic done;
      done = 1'b0;
      i_awaddr  <= adr(idx);
      i_wdata   <= d;
      i_awvalid <= 1'b1;
      i_wvalid  <= 1'b1;
      while (!done) begin
         @(posedge i_mclk);
         if (i_awvalid && o_awready)
            i_awvalid <= 1'b0;
         if (i_wvalid && o_wready)
            i_wvalid <= 1'b0;
         if (o_bvalid) begin
            chk_r(er, o_bresp);
            done = 1'b1;
         end
      end
   endtask : wr_chk

   // One-cycle event pulse followed by an idle cycle, so back-to-back calls never collide.
   task automatic pulse(input tpm_pkg::tpm_evt_t e);
      i_evt <= e;
      @(posedge i_mclk);
      i_evt <= '0;
      @(posedge i_mclk);
   endtask : pulse

   // Watchdog: the whole sequence needs well under a thousand cycles.
   initial begin
      repeat (20000) @(posedge i_mclk);
      error_cnt++;
      end_sim();
   end

   // Main sequence; ready inputs stay high so every answer is taken at the edge it is seen.
   initial begin
      error_cnt = 0;
      check_count = 0;
      i_rstn = 1'b0;
      i_evt = '0;
      i_esf_mode = 1'b0;
      i_awaddr = '0;
      i_araddr = '0;
      i_wdata = '0;
      i_wstrb = 4'hf;
      i_awvalid = 1'b0;
      i_wvalid = 1'b0;
      i_arvalid = 1'b0;
      i_bready = 1'b1;
      i_rready = 1'b1;
      repeat (6) @(posedge i_mclk);
      i_rstn <= 1'b1;
      @(posedge i_mclk);
      rd_chk(tpm_pkg::IDX_SEF, 32'h0, OK);
      rd_chk(tpm_pkg::IDX_CRC_HI, 32'h0, OK);
      rd_chk(tpm_pkg::IDX_CRC_LO, 32'h0, OK);
      rd_chk(tpm_pkg::IDX_SLIP, 32'h0, OK);
      // Slips accumulate, a read clears them and counting starts again from zero.
      repeat (3) pulse(EV_SLIP);
      rd_chk(tpm_pkg::IDX_SLIP, 32'h3, OK);
      repeat (2) pulse(EV_SLIP);
      rd_chk(tpm_pkg::IDX_SLIP, 32'h2, OK);
      rd_chk(tpm_pkg::IDX_SLIP, 32'h0, OK);
      // 259 sync bit errors cross the byte boundary: upper 01, lower 03.
      repeat (259) pulse(EV_CRC);
      rd_chk(tpm_pkg::IDX_CRC_HI, 32'h1, OK);
      rd_chk(tpm_pkg::IDX_CRC_LO, 32'h3, OK);
      rd_chk(tpm_pkg::IDX_CRC_HI, 32'h0, OK);
      pulse(EV_CRC);
      rd_chk(tpm_pkg::IDX_CRC_HI, 32'h0, OK);
      rd_chk(tpm_pkg::IDX_CRC_LO, 32'h1, OK);
      // Superframe mode: a good frame breaks the run, six in a row declare one.
      repeat (5) pulse(EV_ERR);
      pulse(EV_GOOD);
      repeat (5) pulse(EV_ERR);
      rd_chk(tpm_pkg::IDX_SEF, 32'h0, OK);
      pulse(EV_ERR);
      rd_chk(tpm_pkg::IDX_SEF, 32'h1, OK);
      // Extended superframe mode needs twenty-four in a row.
      i_esf_mode <= 1'b1;
      repeat (23) pulse(EV_ERR);
      pulse(EV_GOOD);
      repeat (23) pulse(EV_ERR);
      rd_chk(tpm_pkg::IDX_SEF, 32'h0, OK);
      pulse(EV_ERR);
      repeat (24) pulse(EV_ERR);
      rd_chk(tpm_pkg::IDX_SEF, 32'h2, OK);
      // Sticky status, mask and write-one-to-clear.
      rd_chk(tpm_pkg::IDX_INT_STAT, 32'h7, OK);
      chk_d(32'h0, {31'h0, o_irq});
      wr_chk(tpm_pkg::IDX_INT_MASK, 32'h4, OK);
      rd_chk(tpm_pkg::IDX_INT_MASK, 32'h4, OK);
      // Without the low byte lane the mask write must have no effect.
      i_wstrb <= 4'he;
      wr_chk(tpm_pkg::IDX_INT_MASK, 32'h1, OK);
      i_wstrb <= 4'hf;
      rd_chk(tpm_pkg::IDX_INT_MASK, 32'h4, OK);
      wr_chk(tpm_pkg::IDX_INT_STAT, 32'h7, OK);
      rd_chk(tpm_pkg::IDX_INT_STAT, 32'h0, OK);
      pulse(EV_CRC);
      chk_d(32'h0, {31'h0, o_irq});
      pulse(EV_SLIP);
      chk_d(32'h1, {31'h0, o_irq});
      wr_chk(tpm_pkg::IDX_INT_STAT, 32'h2, OK);
      rd_chk(tpm_pkg::IDX_INT_STAT, 32'h4, OK);
      chk_d(32'h1, {31'h0, o_irq});
      wr_chk(tpm_pkg::IDX_INT_STAT, 32'h4, OK);
      @(posedge i_mclk);
      chk_d(32'h0, {31'h0, o_irq});
      // Unmapped places answer with an error; counter writes are ignored.
      rd_chk(12'h900, 32'h0, BAD);
      wr_chk(12'h900, 32'h5, BAD);
      wr_chk(tpm_pkg::IDX_SLIP, 32'h55, OK);
      rd_chk(tpm_pkg::IDX_SLIP, 32'h1, OK);
      end_sim();
   end
endmodule : tb_tpm_top
